// file: logic/coupler_defs.vh
// Constants for the branch coupler command logic.
// Assumes a slot engine outside that delivers one strobe per time slot.
`ifndef COUPLER_DEFS_VH
`define COUPLER_DEFS_VH

// Control function command codes
`define CMD_STATUS_RW   8'h5A
`define CMD_ALL_OFF     8'h66
`define CMD_DISCHARGE   8'h99
`define CMD_DIRECT_MAIN 8'hA5
`define CMD_SMART_MAIN  8'hCC
`define CMD_SMART_AUX   8'h33

// Status byte field positions
`define ST_MAIN_STAT    0
`define ST_PRIMARY_BRANCH_LEVEL    1
`define ST_AUX_STAT     2
`define ST_SECONDARY_BRANCH_LEVEL     3
`define ST_MAIN_EDGE    4
`define ST_AUX_EDGE     5
`define ST_SWITCH       6
`define ST_MODE         7

// Status control byte field positions
`define SC_WEN_LO       3
`define SC_WEN_HI       4
`define SC_MODE         5
`define SC_SELECT       6
`define SC_DATA         7

// Last slot index, counter start and step, reset values
`define BYTE_LAST       3'h7
`define CNT_ZERO        3'h0
`define CNT_ONE         3'h1
`define MODE_RESET      1'b0
`define SELECT_RESET    1'b0
`define DATA_RESET      1'b0
`define LEVEL_RESET     1'b1

`endif

// file: logic/branch_monitor.v
// Per-branch level latch and falling-edge event flag.
// Assumes level input is synchronous to i_clk.
`default_nettype none
`include "coupler_defs.vh"

module branch_monitor (
	input  wire i_clk,     // System clock
	input  wire i_reset_n, // Async reset, active low
	input  wire i_active,  // Branch through-connected
	input  wire i_pulldown,// Own pull-down is on
	input  wire i_level,   // Sensed branch level
	input  wire i_clear,   // Clear event flag, one-cycle pulse
	output reg  o_level,   // Level held from inactive time
	output reg  o_flag     // Falling edge seen while inactive
);

	reg prev_reg;
	wire fall;

	// Edge only counts while inactive and not self-driven
	assign fall = prev_reg & ~i_level & ~i_active & ~i_pulldown; // see R04

	// Level tracked only while decoupled, flag set beats clear
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prev_reg <= `LEVEL_RESET;
			o_level  <= `LEVEL_RESET;
			o_flag   <= 1'b0;
		end else begin
			prev_reg <= i_level;
			if (!i_active)
				o_level <= i_level; // see R07
			o_flag <= fall | (o_flag & ~i_clear); // see R04
		end
	end

endmodule // branch_monitor

`default_nettype wire

// file: logic/byte_shift_in.v
// Serial-in byte register, least significant bit first.
// Assumes exactly eight shifts make up one byte.
`default_nettype none

module byte_shift_in (
	input  wire       i_clk,     // System clock
	input  wire       i_reset_n, // Async reset, active low
	input  wire       i_shift,   // Take a bit, one-cycle pulse
	input  wire       i_bit,     // Bit from the slot engine
	output reg  [7:0] o_byte     // Bits gathered so far
);

	// New bit enters at the top, so the first bit ends in bit 0
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_byte <= 8'h00;
		else if (i_shift)
			o_byte <= {i_bit, o_byte[7:1]};
	end

endmodule // byte_shift_in

`default_nettype wire

// file: logic/coupler_cmd_ctrl.v
// Command interpreter of a branch coupler behind a single-wire slave port.
// Assumes a slot engine that signals bus reset, start of the function
// phase, one strobe per slot with the sampled bit, and sends o_tx_bit.
//
// Behaviour
// R01: Status bit 0 shows main branch state, 0 active, 1 inactive.
// R02: Status bit 1 shows sensed main branch level.
// R03: Status bits 2 and 3 show auxiliary state and level.
// R04: Falling edge on an inactive branch sets its flag, bits 4 and 5.
// R05: Bit 6 shows followed branch in auto mode, transistor in manual.
// R06: Bit 7 shows control output mode, 1 manual.
// R07: Level bits are only taken while the branch is decoupled.
// R08: Code 66h deactivates branches, clears flags, ends discharge.
// R09: Deactivate-all in auto mode turns the control transistor off.
// R10: Power-on acts as deactivate-all.
// R11: Deactivate-all keeps mode and association settings.
// R12: Code 99h deactivates both, pulls both down until another command.
// R13: Master keeps discharge at least 100 ms; the bench holds it for 50 cycles.
// R14: Master should end discharge with 66h or 5Ah.
// R15: Master should read flags before sending 66h.
// R16: Code A5h activates main, deactivates auxiliary, updates transistor.
// R17: Smart-on main, code CCh, first deactivates the main branch.
// R18: Eight write slots after smart-on hold the branch low.
// R19: Eight read slots release it and return its level.
// R20: After sixteen slots main connects, auxiliary off, transistor updates.
// R21: Bus reset during the low period releases the pull-down at once.
// R22: Code 33h does the same on the auxiliary branch.
// R23: Code 5Ah takes a control byte, returns status twice.
// R24: Control byte applies only when its bits 3 and 4 are zero.
// R25: Bit 6 selects association, bit 5 manual mode; defaults zero.
// R26: In manual mode bit 7 drives the control transistor.
// R27: Unknown codes change nothing; the port stays silent until reset.
`default_nettype none
`include "coupler_defs.vh"

module coupler_cmd_ctrl (
	input  wire       i_clk,          // System clock, 100 MHz
	input  wire       i_reset_n,      // Power-on reset, active low
	input  wire       i_bus_reset,    // Bus reset pulse seen
	input  wire       i_func_start,   // ROM phase passed, pulse
	input  wire       i_slot_strobe,  // One slot finished, pulse
	input  wire       i_slot_bit,     // Bit sampled in that slot
	input  wire       i_main_level,   // Sensed main branch level
	input  wire       i_aux_level,    // Sensed auxiliary level
	output reg        o_main_active,  // Main branch through-connected
	output reg        o_aux_active,   // Aux branch through-connected
	output reg        o_main_pulldown,// Main branch pull-down on
	output reg        o_aux_pulldown, // Aux branch pull-down on
	output reg        o_ctrl_on,      // Control transistor conducting
	output reg        o_tx_bit,       // Bit for next read slot
	output reg  [7:0] o_status        // Coupler status byte
);

	localparam S_IDLE   = 3'h0;
	localparam S_CMD    = 3'h1;
	localparam S_CTLIN  = 3'h2;
	localparam S_TX     = 3'h3;
	localparam S_RSTLOW = 3'h4;
	localparam S_RSTHI  = 3'h5;
	localparam S_SILENT = 3'h6;

	reg  [2:0] state_reg, state_next;
	reg  [2:0] cnt_reg, cnt_next;
	reg  [7:0] cmd_reg, cmd_next;
	reg  [7:0] tx_shift_reg, tx_shift_next;
	reg  [7:0] tx_hold_reg, tx_hold_next;
	reg        main_act_next, aux_act_next;
	reg        discharge_reg, discharge_next;
	reg        mode_reg, mode_next;
	reg        select_reg, select_next;
	reg        data_reg, data_next;
	reg        clear_flags;
	reg        ctrl_next;
	reg        tx_bit_next;
	reg        main_pd_next, aux_pd_next;
	reg        target_aux;

	wire [7:0] rx_byte;
	wire [7:0] rx_full;
	wire       shift_rx;
	wire       main_level, aux_level;
	wire       main_flag, aux_flag;
	wire       last_slot;

	// Compose the status byte from settings and branch state
	function [7:0] status_byte;
		input mode;
		input sel;
		input data;
		input main_act;
		input aux_act;
		input m_lvl;
		input a_lvl;
		input m_flag;
		input a_flag;
		reg   ctl;
		begin
			ctl = mode ? data : (sel ? aux_act : main_act);
			status_byte = 8'h00;
			status_byte[`ST_MAIN_STAT] = ~main_act; // see R01
			status_byte[`ST_PRIMARY_BRANCH_LEVEL] = m_lvl;     // see R02
			status_byte[`ST_AUX_STAT]  = ~aux_act;  // see R03
			status_byte[`ST_SECONDARY_BRANCH_LEVEL]  = a_lvl;     // see R03
			status_byte[`ST_MAIN_EDGE] = m_flag;    // see R04
			status_byte[`ST_AUX_EDGE]  = a_flag;    // see R04
			status_byte[`ST_SWITCH]    = mode ? ctl : sel; // see R05
			status_byte[`ST_MODE]      = mode;      // see R06
		end
	endfunction

	// Received byte including the bit of the current slot
	assign rx_full   = {i_slot_bit, rx_byte[7:1]};
	assign last_slot = (cnt_reg == `BYTE_LAST);
	assign shift_rx  = i_slot_strobe & ~i_bus_reset &
	                   ((state_reg == S_CMD) || (state_reg == S_CTLIN));

	byte_shift_in u_rx (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_shift   (shift_rx),
		.i_bit     (i_slot_bit),
		.o_byte    (rx_byte)
	);

	branch_monitor u_main_mon (
		.i_clk      (i_clk),
		.i_reset_n  (i_reset_n),
		.i_active   (o_main_active),
		.i_pulldown (o_main_pulldown),
		.i_level    (i_main_level),
		.i_clear    (clear_flags),
		.o_level    (main_level),
		.o_flag     (main_flag)
	);

	branch_monitor u_aux_mon (
		.i_clk      (i_clk),
		.i_reset_n  (i_reset_n),
		.i_active   (o_aux_active),
		.i_pulldown (o_aux_pulldown),
		.i_level    (i_aux_level),
		.i_clear    (clear_flags),
		.o_level    (aux_level),
		.o_flag     (aux_flag)
	);

	// Command sequencing and branch switching
	always @* begin
		state_next     = state_reg;
		cnt_next       = cnt_reg;
		cmd_next       = cmd_reg;
		tx_shift_next  = tx_shift_reg;
		tx_hold_next   = tx_hold_reg;
		main_act_next  = o_main_active;
		aux_act_next   = o_aux_active;
		discharge_next = discharge_reg;
		mode_next      = mode_reg;
		select_next    = select_reg;
		data_next      = data_reg;
		clear_flags    = 1'b0;
		if (i_bus_reset) begin
			state_next = S_IDLE; // see R21
			cnt_next   = `CNT_ZERO;
		end else begin
			case (state_reg)
			S_IDLE: begin
				if (i_func_start) begin
					state_next = S_CMD;
					cnt_next   = `CNT_ZERO;
				end
			end
			S_CMD: begin
				if (i_slot_strobe) begin
					cnt_next = cnt_reg + `CNT_ONE;
					if (last_slot) begin
						cmd_next       = rx_full;
						cnt_next       = `CNT_ZERO;
						discharge_next = 1'b0;
						tx_hold_next   = rx_full;
						tx_shift_next  = rx_full;
						state_next     = S_TX;
						case (rx_full)
						`CMD_ALL_OFF: begin
							main_act_next = 1'b0; // see R08
							aux_act_next  = 1'b0; // see R08
							clear_flags   = 1'b1; // see R08
						end
						`CMD_DISCHARGE: begin
							main_act_next  = 1'b0; // see R12
							aux_act_next   = 1'b0; // see R12
							discharge_next = 1'b1; // see R12
						end
						`CMD_DIRECT_MAIN: begin
							main_act_next = 1'b1; // see R16
							aux_act_next  = 1'b0; // see R16
						end
						`CMD_SMART_MAIN: begin
							main_act_next = 1'b0; // see R17
							state_next    = S_RSTLOW;
						end
						`CMD_SMART_AUX: begin
							aux_act_next = 1'b0; // see R22
							state_next   = S_RSTLOW;
						end
						`CMD_STATUS_RW: begin
							state_next = S_CTLIN;
						end
						default: begin
							discharge_next = discharge_reg; // see R27
							state_next     = S_SILENT;      // see R27
						end
						endcase
					end
				end
			end
			S_CTLIN: begin
				if (i_slot_strobe) begin
					cnt_next = cnt_reg + `CNT_ONE;
					if (last_slot) begin
						cnt_next = `CNT_ZERO;
						if (!rx_full[`SC_WEN_LO] &&
						    !rx_full[`SC_WEN_HI]) begin // see R24
							mode_next   = rx_full[`SC_MODE];   // see R25
							select_next = rx_full[`SC_SELECT]; // see R25
							data_next   = rx_full[`SC_DATA];   // see R26
						end
						tx_hold_next = status_byte(mode_next,
							select_next, data_next, o_main_active,
							o_aux_active, main_level, aux_level,
							main_flag, aux_flag); // see R23
						tx_shift_next = tx_hold_next;
						state_next    = S_TX;
					end
				end
			end
			S_TX: begin
				if (i_slot_strobe) begin
					cnt_next      = cnt_reg + `CNT_ONE;
					tx_shift_next = {1'b1, tx_shift_reg[7:1]};
					if (last_slot) begin
						tx_shift_next = tx_hold_reg; // see R23
						cnt_next      = `CNT_ZERO;
					end
				end
			end
			S_RSTLOW: begin
				if (i_slot_strobe) begin
					cnt_next = cnt_reg + `CNT_ONE;
					if (last_slot) begin
						cnt_next   = `CNT_ZERO; // see R18
						state_next = S_RSTHI;
					end
				end
			end
			S_RSTHI: begin
				if (i_slot_strobe) begin
					cnt_next = cnt_reg + `CNT_ONE;
					if (last_slot) begin
						cnt_next      = `CNT_ZERO;
						// Target decoded here; target_aux has one driver
						main_act_next = (cmd_reg != `CMD_SMART_AUX); // see R20
						aux_act_next  = (cmd_reg == `CMD_SMART_AUX); // see R22
						state_next    = S_SILENT;
					end
				end
			end
			S_SILENT: begin
				state_next = S_SILENT; // see R27
			end
			default: begin
				state_next = S_IDLE;
			end
			endcase
		end
	end

	// Output values for the next cycle
	always @* begin
		target_aux  = (cmd_next == `CMD_SMART_AUX);
		ctrl_next   = mode_next ? data_next :
		              (select_next ? aux_act_next : main_act_next); // see R09
		main_pd_next = discharge_next |
		               ((state_next == S_RSTLOW) & ~target_aux); // see R18
		aux_pd_next  = discharge_next |
		               ((state_next == S_RSTLOW) & target_aux);  // see R22
		case (state_next)
		S_TX:    tx_bit_next = tx_shift_next[0];
		S_RSTHI: tx_bit_next = target_aux ? i_aux_level :
		                       i_main_level; // see R19
		default: tx_bit_next = 1'b1;
		endcase
	end

	// State and output registers; reset equals deactivate-all
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg       <= S_IDLE;
			cnt_reg         <= `CNT_ZERO;
			cmd_reg         <= 8'h00;
			tx_shift_reg    <= 8'hFF;
			tx_hold_reg     <= 8'hFF;
			discharge_reg   <= 1'b0;
			mode_reg        <= `MODE_RESET;   // see R10
			select_reg      <= `SELECT_RESET; // see R10
			data_reg        <= `DATA_RESET;
			o_main_active   <= 1'b0;          // see R10
			o_aux_active    <= 1'b0;          // see R10
			o_main_pulldown <= 1'b0;
			o_aux_pulldown  <= 1'b0;
			o_ctrl_on       <= 1'b0;
			o_tx_bit        <= 1'b1;
			o_status        <= 8'h05;
		end else begin
			state_reg       <= state_next;
			cnt_reg         <= cnt_next;
			cmd_reg         <= cmd_next;
			tx_shift_reg    <= tx_shift_next;
			tx_hold_reg     <= tx_hold_next;
			discharge_reg   <= discharge_next;
			mode_reg        <= mode_next;   // see R11
			select_reg      <= select_next; // see R11
			data_reg        <= data_next;
			o_main_active   <= main_act_next;
			o_aux_active    <= aux_act_next;
			o_main_pulldown <= main_pd_next;
			o_aux_pulldown  <= aux_pd_next;
			o_ctrl_on       <= ctrl_next; // see R16
			o_tx_bit        <= tx_bit_next;
			o_status        <= status_byte(mode_reg, select_reg, data_reg,
				o_main_active, o_aux_active, main_level, aux_level,
				main_flag, aux_flag);
		end
	end

endmodule // coupler_cmd_ctrl

`default_nettype wire

// file: sim/coupler_cmd_ctrl_properties.sv
// Timing checker for the coupler command logic, bound to its top module.
// Assumes the bench never moves a level input during a command boundary.
`default_nettype none

module coupler_cmd_ctrl_checker (
	input wire logic       i_clk,           // System clock
	input wire logic       i_reset_n,       // Async reset, active low
	input wire logic       i_bus_reset,     // Bus reset pulse
	input wire logic       i_slot_strobe,   // Slot strobe
	input wire logic       i_main_level,    // Main level
	input wire logic       o_main_active,   // Main connected
	input wire logic       o_aux_active,    // Aux connected
	input wire logic       o_main_pulldown, // Main pull-down
	input wire logic       o_aux_pulldown,  // Aux pull-down
	input wire logic       o_ctrl_on,       // Control transistor
	input wire logic [7:0] o_status         // Status byte
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// State bits follow the branch outputs once settled
	property p_main_stat;
		$stable(o_main_active) |-> o_status[0] != o_main_active;
	endproperty
	a_main_stat: assert property (p_main_stat)
		else $error("main state bit wrong");
	property p_aux_stat;
		$stable(o_aux_active) |-> o_status[2] != o_aux_active;
	endproperty
	a_aux_stat: assert property (p_aux_stat)
		else $error("aux state bit wrong");
	// Never both branches through-connected
	property p_one_branch;
		!(o_main_active && o_aux_active);
	endproperty
	a_one_branch: assert property (p_one_branch)
		else $error("both branches active");
	// Auto mode: transistor follows the associated branch
	property p_auto_ctrl;
		!o_status[7] && $stable(o_status[7:6]) && $stable(o_ctrl_on) &&
		$stable(o_main_active) && $stable(o_aux_active) |->
		o_ctrl_on == (o_status[6] ? o_aux_active : o_main_active);
	endproperty
	a_auto_ctrl: assert property (p_auto_ctrl)
		else $error("auto control output wrong");
	// Manual mode: bit 6 reports the transistor
	property p_manual_ctrl;
		o_status[7] && $stable(o_status[7:6]) && $stable(o_ctrl_on) |->
		o_ctrl_on == o_status[6];
	endproperty
	a_manual_ctrl: assert property (p_manual_ctrl)
		else $error("manual control output wrong");
	// Bus reset during a smart-on low period frees the line
	property p_abort;
		i_bus_reset && (o_main_pulldown != o_aux_pulldown) |=>
		!o_main_pulldown && !o_aux_pulldown;
	endproperty
	a_abort: assert property (p_abort)
		else $error("pull-down kept after bus reset");
	// Discharge holds while no slot completes a command
	property p_hold_discharge;
		o_main_pulldown && o_aux_pulldown && !i_slot_strobe &&
		!$past(i_slot_strobe) |=> o_main_pulldown && o_aux_pulldown;
	endproperty
	a_hold_discharge: assert property (p_hold_discharge)
		else $error("discharge ended early");
	// Falling edge on an idle main branch raises its flag
	property p_main_flag;
		$fell(i_main_level) && !o_main_active && !o_main_pulldown |->
		##[1:3] o_status[4];
	endproperty
	a_main_flag: assert property (p_main_flag)
		else $error("main event flag not set");
endmodule // coupler_cmd_ctrl_checker

bind coupler_cmd_ctrl coupler_cmd_ctrl_checker i_checker (
	.i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus_reset(i_bus_reset),
	.i_slot_strobe(i_slot_strobe), .i_main_level(i_main_level),
	.o_main_active(o_main_active), .o_aux_active(o_aux_active),
	.o_main_pulldown(o_main_pulldown), .o_aux_pulldown(o_aux_pulldown),
	.o_ctrl_on(o_ctrl_on), .o_status(o_status)
);
`default_nettype wire

// file: sim/slot_master.sv
// Bus master model seen through the slot engine: reset, start, slots.
// Assumes the device answers on o_tx_bit one edge after each strobe.
`default_nettype none

module slot_master #(
	parameter int hold_cycles = 10000000 // 100 ms at 100 MHz
) (
	input  wire logic i_clk,       // System clock
	input  wire logic i_tx_bit,    // Device read slot bit
	output var  logic o_bus_reset, // Bus reset pulse
	output var  logic o_func_start,// Function phase start
	output var  logic o_strobe,    // Slot strobe
	output var  logic o_bit        // Slot bit
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle line values from time zero
	initial begin
		o_bus_reset = 1'b0;
		o_func_start = 1'b0;
		o_strobe = 1'b0;
		o_bit = 1'b1;
	end
	// Bus reset then function phase
	task start();
		@(negedge i_clk) o_bus_reset = 1'b1;
		@(negedge i_clk) o_bus_reset = 1'b0;
		o_func_start = 1'b1;
		@(negedge i_clk) o_func_start = 1'b0;
	endtask
	// One slot; the bit line is inverted once released
	task slot(input logic b, output logic r);
		@(negedge i_clk) r = i_tx_bit;
		o_bit = b;
		o_strobe = 1'b1;
		@(negedge i_clk) o_strobe = 1'b0;
		o_bit = ~b;
	endtask
	// Byte of eight slots, least significant bit first
	task xfer(input logic [7:0] w, output logic [7:0] r);
		for (int i = 0; i < 8; i++)
			slot(w[i], r[i]);
	endtask
	// Discharge kept for the minimum time
	task hold();
		repeat (hold_cycles) @(negedge i_clk);
	endtask
endmodule // slot_master
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the coupler command logic.
// Assumes the slot master model stands in for the bus master.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       i_clk, i_reset_n, i_main_level, i_aux_level, x;
	logic       bus_rst, f_start, strobe, s_bit, tx;
	logic       m_act, a_act, m_pd, a_pd, ctrl;
	logic [7:0] status, r, cb;
	int         miscompares, comparisons;
	int         ma, aa, pm, pa, mode, sel, data, fm, fa, lm = 1, la = 1;

	initial i_clk = 1'b0;
	always #5 i_clk = ~i_clk;

	coupler_cmd_ctrl i_dut (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus_reset(bus_rst),
		.i_func_start(f_start), .i_slot_strobe(strobe), .i_slot_bit(s_bit),
		.i_main_level(i_main_level), .i_aux_level(i_aux_level),
		.o_main_active(m_act), .o_aux_active(a_act), .o_main_pulldown(m_pd),
		.o_aux_pulldown(a_pd), .o_ctrl_on(ctrl), .o_tx_bit(tx),
		.o_status(status)
	);
	slot_master #(.hold_cycles(50)) i_master (
		.i_clk(i_clk), .i_tx_bit(tx), .o_bus_reset(bus_rst),
		.o_func_start(f_start), .o_strobe(strobe), .o_bit(s_bit)
	);

	// Expected status byte from the model
	function automatic logic [7:0] st();
		st = {mode[0], mode ? data[0] : sel[0], fa[0], fm[0], la[0],
			!aa[0], lm[0], !ma[0]};
	endfunction
	task cmp(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// Status and all branch outputs against the model
	task check_all();
		repeat (2) @(negedge i_clk);
		cmp(status, st());
		x = mode ? data[0] : (sel ? aa[0] : ma[0]);
		cmp({3'h0, m_act, a_act, m_pd, a_pd, ctrl},
			{3'h0, ma[0], aa[0], pm[0], pa[0], x});
	endtask
	task run(input logic [7:0] code);
		i_master.start();
		i_master.xfer(code, r);
	endtask
	task final_report();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#100us;
		miscompares++;
		final_report();
	end
	// Main sequence
	initial begin
		void'($urandom(56132));
		i_reset_n = 1'b0;
		i_main_level = 1'b1;
		i_aux_level = 1'b1;
		repeat (2) @(negedge i_clk);
		i_reset_n = 1'b1;
		check_all();
		for (int k = 0; k < 8; k++) begin
			cb = 8'($urandom);
			if (!k[0]) cb[4:3] = 2'h0;
			if (k == 6) cb = 8'hA0;
			if (k == 7) cb = 8'h40;
			run(8'h5A);
			i_master.xfer(cb, r);
			if (cb[4:3] == 2'h0) begin
				mode = cb[5];
				sel = cb[6];
				data = cb[7];
			end
			i_master.xfer(8'hFF, r);
			cmp(r, st());
			i_master.xfer(8'hFF, r);
			cmp(r, st());
			check_all();
		end
		run(8'hA5);
		ma = 1;
		check_all();
		i_master.xfer(8'hFF, r);
		cmp(r, 8'hA5);
		run(8'hCC);
		ma = 0;
		pm = 1;
		check_all();
		repeat (4) i_master.slot(1'b0, x);
		i_master.start();
		pm = 0;
		check_all();
		i_aux_level = 1'b0;
		la = 0;
		fa = 1;
		run(8'h33);
		pa = 1;
		check_all();
		i_master.xfer(8'h00, r);
		pa = 0;
		i_master.xfer(8'hFF, r);
		cmp(r, 8'h00);
		aa = 1;
		check_all();
		@(negedge i_clk) i_main_level = 1'b0;
		lm = 0;
		fm = 1;
		check_all();
		@(negedge i_clk) i_main_level = 1'b1;
		lm = 1;
		// Flags read back before they are cleared, settings kept
		run(8'h5A);
		i_master.xfer(8'h18, r);
		i_master.xfer(8'hFF, r);
		cmp(r, st());
		run(8'h66);
		aa = 0;
		fm = 0;
		fa = 0;
		check_all();
		run(8'h99);
		pm = 1;
		pa = 1;
		check_all();
		i_master.hold();
		i_master.start();
		check_all();
		run(8'h66);
		pm = 0;
		pa = 0;
		check_all();
		run(8'h12);
		check_all();
		i_master.xfer(8'hFF, r);
		cmp(r, 8'hFF);
		run(8'hCC);
		i_master.xfer(8'h00, r);
		i_master.xfer(8'hFF, r);
		cmp(r, 8'hFF);
		ma = 1;
		check_all();
		final_report();
	end
endmodule // tb_top
`default_nettype wire
